// *** rtl/msv_memory_security.sv ***
// Memory security gate, option load, backdoor key and vector redirect
`timescale 1ns/1ps
`default_nettype none
module msv_memory_security #(
  parameter logic [15:0] FLASH_BASE = 16'hF800,
  parameter logic [15:0] RAM_BASE = 16'h0060,
  parameter logic [15:0] RAM_LAST = 16'h00DF
) (
  input wire logic ref_clk,
  input wire logic srst,
  // Flash array option and key contents
  input wire logic [7:0] nvOptByte,
  input wire logic [7:0] nvProtByte,
  input wire logic [63:0] nvBackKey,
  input wire logic backgroundModePin,
  input wire logic powerOnEvent,
  input wire logic stop1Wakeup,
  input wire logic massEraseBlankOk,
  // CPU and background access path
  input wire logic [15:0] cpuFetchAddr,
  input wire logic [15:0] cpuAddr,
  input wire logic cpuRead,
  input wire logic cpuWrite,
  input wire logic cpuVectorFetch,
  input wire logic bdcAccess,
  input wire logic [7:0] memRdata,
  output logic [15:0] memAddr,
  output logic memRead,
  output logic memWrite,
  output logic [7:0] cpuRdata,
  output logic accessBlocked,
  // Backdoor key entry from the CPU
  input wire logic keyByteValid,
  input wire logic [7:0] keyByte,
  // Flash program and erase requests
  input wire logic [15:0] flashPgmAddr,
  input wire logic flashPgmReq,
  output logic flashPgmGrant,
  output logic debugEnable,
  output logic activeBackground,
  output logic secure,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  import msv_pkg::*;

  logic [7:0] optQ;
  logic [7:0] protQ;
  logic bgndQ;
  logic keyUnlockQ;
  logic blankUnlockQ;
  logic ramUndefQ;
  logic debugReqQ;
  logic respQ;
  logic [31:0] rdataQ;
  msv_key_state_t keyStateQ;
  msv_key_state_t keyStateD;
  logic [MSV_KEY_IDX_W-1:0] keyIdxQ;
  logic [MSV_KEY_IDX_W-1:0] keyIdxD;

  logic codeSecure;
  logic fetchInSecure;
  logic targetSecure;
  logic blocked;
  logic protEnabled;
  logic [15:0] protStart;
  logic redirActive;
  logic [15:0] vecAddr;
  logic keyAllowed;
  logic [7:0] expectByte;
  logic busReq;
  logic busDone;
  logic ramClrWrite;
  logic [7:0] statusByte;
  logic [7:0] keyBytes [MSV_KEY_BYTES];
  logic ctrlWrite;
  logic vecGuard;
  logic [31:0] rdataD;

  // ----------------------------------------------------------------
  // Working option register
  // ----------------------------------------------------------------
  // copy option byte during reset
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      optQ <= nvOptByte;
    end
  end

  // protect byte held likewise
  // Loaded beside the option byte so redirect and guard agree from release on
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      protQ <= nvProtByte;
    end
  end

  // mode pin captured at reset release
  // Last value seen while reset is high is the one at the rising edge
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      bgndQ <= !backgroundModePin;
    end
  end
  assign activeBackground = bgndQ;

  // ----------------------------------------------------------------
  // Security state
  // ----------------------------------------------------------------
  // only 1:0 is unsecured
  assign codeSecure = (optQ[MSV_OPT_SEC_HI_BIT:MSV_OPT_SEC_LO_BIT] != MSV_SEC_UNSECURED);
  assign secure = codeSecure && !keyUnlockQ && !blankUnlockQ;

  // blank check opens the part until reset
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      blankUnlockQ <= 1'b0;
    end else if (massEraseBlankOk) begin
      blankUnlockQ <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Access classification and gating
  // ----------------------------------------------------------------
  // flash and RAM are the secure resources
  // direct page RAM decoded as ordinary RAM
  function automatic logic inSecureMem(input logic [15:0] a);
    inSecureMem = (a >= FLASH_BASE) || ((a >= RAM_BASE) && (a <= RAM_LAST));
  endfunction

  assign fetchInSecure = inSecureMem(cpuFetchAddr) && !bdcAccess;
  assign targetSecure = inSecureMem(memAddr);
  // background commands pass the same gate
  assign blocked = secure && targetSecure && (bdcAccess || !fetchInSecure);
  assign accessBlocked = blocked && (cpuRead || cpuWrite);

  // same-cycle gating
  // Gating must be combinational, otherwise a blocked write would land
  assign memRead = cpuRead && !blocked;
  assign memWrite = cpuWrite && !blocked;
  assign cpuRdata = blocked ? 8'h00 : memRdata;

  // ----------------------------------------------------------------
  // Block protection and vector redirect
  // ----------------------------------------------------------------
  assign protEnabled = !protQ[MSV_PROT_DIS_BIT];
  assign protStart = {protQ[MSV_PROT_SIZE_HI:MSV_PROT_SIZE_LO], {MSV_PROT_GRAIN_BITS{1'b0}}};

  // region always reaches the vectors
  // Explicit vector guard, so an odd size field can never expose the vectors
  assign vecGuard = protEnabled && (flashPgmAddr >= MSV_VEC_FIRST);
  assign flashPgmGrant = flashPgmReq && !vecGuard && !(protEnabled && (flashPgmAddr >= protStart));

  // Only vector fetches are steered; data reads pass straight through
  msv_vector_redirect u_redirect (
    .fetchAddr(cpuAddr),
    .vectorFetch(cpuVectorFetch),
    .redirectDisable(optQ[MSV_OPT_REDIR_DIS_BIT]),
    .protStart(protStart),
    .protEnabled(protEnabled),
    .flashBase(FLASH_BASE),
    .redirectActive(redirActive),
    .outAddr(vecAddr)
  );
  assign memAddr = vecAddr;

  // ----------------------------------------------------------------
  // Backdoor key comparison
  // ----------------------------------------------------------------
  // disabled when key-enable bit is 0
  assign keyAllowed = optQ[MSV_OPT_KEY_EN_BIT] && fetchInSecure && !bdcAccess;
  // Key bytes as an indexed table, byte 0 compared first
  // Index stops at the last byte, so no read past the table
  for (genvar gi = 0; gi < MSV_KEY_BYTES; gi++) begin : g_key
    assign keyBytes[gi] = nvBackKey[gi*8 +: 8];
  end
  assign expectByte = keyBytes[keyIdxQ];

  always_comb begin
    keyStateD = keyStateQ;
    keyIdxD = keyIdxQ;
    case (keyStateQ)
      MSV_KEY_IDLE, MSV_KEY_MATCH: begin
        if (keyByteValid && keyAllowed) begin
          if (keyByte != expectByte) begin
            keyStateD = MSV_KEY_FAILED;
          end else if (keyIdxQ == MSV_KEY_IDX_W'(MSV_KEY_BYTES - 1)) begin
            keyStateD = MSV_KEY_OPEN;
          end else begin
            keyStateD = MSV_KEY_MATCH;
            keyIdxD = MSV_KEY_IDX_W'(keyIdxQ + 1'b1);
          end
        end
      end
      MSV_KEY_OPEN: begin
        keyStateD = MSV_KEY_OPEN;
      end
      MSV_KEY_FAILED: begin
        keyStateD = MSV_KEY_FAILED;
      end
      default: begin
        keyStateD = MSV_KEY_IDLE;
      end
    endcase
  end

  // Failed attempt stays failed until reset, so guessing costs a reset each
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      keyStateQ <= MSV_KEY_IDLE;
      keyIdxQ <= '0;
    end else begin
      keyStateQ <= keyStateD;
      keyIdxQ <= keyIdxD;
    end
  end
  assign keyUnlockQ = (keyStateQ == MSV_KEY_OPEN);

  // ----------------------------------------------------------------
  // RAM retention status
  // ----------------------------------------------------------------
  // undefined after power-on or stop1, kept over reset
  // Set wins over a software clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (powerOnEvent || stop1Wakeup) begin
      ramUndefQ <= 1'b1;
    end else if (ramClrWrite) begin
      ramUndefQ <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Debug enable
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      debugReqQ <= 1'b0;
    end else if (ctrlWrite) begin
      debugReqQ <= avs_writedata[MSV_CTRL_DEBUG_REQ];
    end
  end
  assign debugEnable = debugReqQ && !secure;

  // ----------------------------------------------------------------
  // Avalon-MM slave, one wait state
  // ----------------------------------------------------------------
  assign busReq = avs_read || avs_write;
  assign busDone = busReq && respQ;
  assign avs_waitrequest = busReq && !respQ;
  // Writes land only on the answer edge
  assign ctrlWrite = busDone && avs_write && (avs_address == MSV_REG_CTRL);
  assign ramClrWrite = ctrlWrite && avs_writedata[MSV_CTRL_RAM_CLR];

  always_comb begin
    statusByte = 8'h00;
    statusByte[MSV_ST_SECURE] = secure;
    statusByte[MSV_ST_KEY_UNLOCK] = keyUnlockQ;
    statusByte[MSV_ST_BLANK_UNLOCK] = blankUnlockQ;
    statusByte[MSV_ST_RAM_UNDEF] = ramUndefQ;
    statusByte[MSV_ST_ACTIVE_BGND] = bgndQ;
    statusByte[MSV_ST_REDIR_ACTIVE] = redirActive;
    statusByte[MSV_ST_DEBUG_EN] = debugEnable;
    statusByte[MSV_ST_KEY_FAIL] = (keyStateQ == MSV_KEY_FAILED);
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      respQ <= 1'b0;
    end else begin
      respQ <= busReq && !respQ;
    end
  end

  // ----------------------------------------------------------------
  // Register read path
  // ----------------------------------------------------------------
  // Unmapped addresses read zero and ignore writes
  // Captured on the taking edge, so the word stands at the answer edge
  always_comb begin
    rdataD = rdataQ;
    if (avs_read && !respQ) begin
      case (avs_address)
        MSV_REG_STATUS: begin
          rdataD = {24'h00_0000, statusByte};
        end
        MSV_REG_OPTION: begin
          rdataD = {24'h00_0000, optQ};
        end
        MSV_REG_PROTECT: begin
          rdataD = {24'h00_0000, protQ};
        end
        MSV_REG_CTRL: begin
          rdataD = {31'h0000_0000, debugReqQ};
        end
        default: begin
          rdataD = MSV_ZERO_WORD;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rdataQ <= MSV_ZERO_WORD;
    end else begin
      rdataQ <= rdataD;
    end
  end
  assign avs_readdata = rdataQ;

endmodule
`default_nettype wire

// *** include/msv_pkg.sv ***
// Constants shared by the memory security and vector redirect logic
package msv_pkg;

  // ----------------------------------------------------------------
  // Nonvolatile option byte layout
  // ----------------------------------------------------------------
  localparam logic [15:0] MSV_NV_PROT_ADDR = 16'hFFBD;
  localparam logic [15:0] MSV_NV_OPT_ADDR = 16'hFFBF;
  localparam int MSV_OPT_KEY_EN_BIT = 7;
  localparam int MSV_OPT_REDIR_DIS_BIT = 6;
  localparam int MSV_OPT_SEC_HI_BIT = 1;
  localparam int MSV_OPT_SEC_LO_BIT = 0;
  localparam logic [1:0] MSV_SEC_UNSECURED = 2'h2;
  localparam logic [7:0] MSV_OPT_ERASED = 8'hFF;

  // ----------------------------------------------------------------
  // Flash protect byte layout
  // ----------------------------------------------------------------
  localparam int MSV_PROT_DIS_BIT = 0;
  localparam int MSV_PROT_SIZE_HI = 7;
  localparam int MSV_PROT_SIZE_LO = 1;
  localparam int MSV_PROT_GRAIN_BITS = 9;

  // ----------------------------------------------------------------
  // Vector area
  // ----------------------------------------------------------------
  localparam logic [15:0] MSV_VEC_FIRST = 16'hFFC0;
  localparam logic [15:0] MSV_VEC_LAST = 16'hFFFD;
  localparam logic [15:0] MSV_RESET_VEC = 16'hFFFE;
  localparam logic [15:0] MSV_DIRECT_PAGE_END = 16'h0100;

  // ----------------------------------------------------------------
  // Backdoor key
  // ----------------------------------------------------------------
  localparam int MSV_KEY_BYTES = 8;
  localparam int MSV_KEY_IDX_W = 3;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] MSV_REG_STATUS = 4'h0;
  localparam logic [3:0] MSV_REG_OPTION = 4'h4;
  localparam logic [3:0] MSV_REG_PROTECT = 4'h8;
  localparam logic [3:0] MSV_REG_CTRL = 4'hC;
  localparam int MSV_ST_SECURE = 0;
  localparam int MSV_ST_KEY_UNLOCK = 1;
  localparam int MSV_ST_BLANK_UNLOCK = 2;
  localparam int MSV_ST_RAM_UNDEF = 3;
  localparam int MSV_ST_ACTIVE_BGND = 4;
  localparam int MSV_ST_REDIR_ACTIVE = 5;
  localparam int MSV_ST_DEBUG_EN = 6;
  localparam int MSV_ST_KEY_FAIL = 7;
  localparam int MSV_CTRL_DEBUG_REQ = 0;
  localparam int MSV_CTRL_RAM_CLR = 1;
  localparam logic [31:0] MSV_ZERO_WORD = 32'h0000_0000;

  typedef enum logic [1:0] {
    MSV_KEY_IDLE = 2'b00,
    MSV_KEY_MATCH = 2'b01,
    MSV_KEY_OPEN = 2'b10,
    MSV_KEY_FAILED = 2'b11
  } msv_key_state_t;

endpackage

// *** rtl/msv_vector_redirect.sv ***
// Interrupt vector redirection below the protected flash region
`timescale 1ns/1ps
`default_nettype none
module msv_vector_redirect (
  input wire logic [15:0] fetchAddr,
  input wire logic vectorFetch,
  input wire logic redirectDisable,
  input wire logic [15:0] protStart,
  input wire logic protEnabled,
  input wire logic [15:0] flashBase,
  output logic redirectActive,
  output logic [15:0] outAddr
);
  import msv_pkg::*;

  logic partialProt;
  logic inVectors;

  // ----------------------------------------------------------------
  // Redirect decision
  // ----------------------------------------------------------------
  // partial protection only
  assign partialProt = protEnabled && (protStart > flashBase);
  assign redirectActive = !redirectDisable && partialProt;
  assign inVectors = (fetchAddr >= MSV_VEC_FIRST) && (fetchAddr <= MSV_VEC_LAST);

  // same offset below region start
  // Region ends at the top of memory, so start is minus its size modulo 64K
  always_comb begin
    if (vectorFetch && inVectors && redirectActive) begin
      outAddr = 16'(fetchAddr + protStart);
    end else begin
      outAddr = fetchAddr;
    end
  end

endmodule
`default_nettype wire

// *** sim/msv_memory_security_props.sv ***
// Assertion checker for the memory security block
`timescale 1ns/1ps
`default_nettype none
module msv_memory_security_props #(
  parameter logic [15:0] FLASH_BASE = 16'hF800,
  parameter logic [15:0] RAM_BASE = 16'h0060,
  parameter logic [15:0] RAM_LAST = 16'h00DF
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [7:0] nvOptByte,
  input wire logic [7:0] nvProtByte,
  input wire logic backgroundModePin,
  input wire logic [15:0] cpuFetchAddr,
  input wire logic [15:0] cpuAddr,
  input wire logic cpuRead,
  input wire logic cpuWrite,
  input wire logic cpuVectorFetch,
  input wire logic bdcAccess,
  input wire logic [7:0] memRdata,
  input wire logic [15:0] memAddr,
  input wire logic memWrite,
  input wire logic [7:0] cpuRdata,
  input wire logic accessBlocked,
  input wire logic [15:0] flashPgmAddr,
  input wire logic flashPgmReq,
  input wire logic flashPgmGrant,
  input wire logic debugEnable,
  input wire logic activeBackground,
  input wire logic secure
);
  // ----------------------------------------
  // Own copy of the option bytes
  // ----------------------------------------
  // Kept apart from the design so a stuck load shows up
  logic [7:0] optQ;
  logic [7:0] protQ;
  logic pinQ;
  logic [15:0] protStart;
  logic redirOn;
  logic tgtSec;
  logic orgSec;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      optQ <= nvOptByte;
      protQ <= nvProtByte;
      pinQ <= backgroundModePin;
    end
  end
  assign protStart = {protQ[7:1], 9'h000};
  assign redirOn = !optQ[6] && !protQ[0] && (protStart > FLASH_BASE);
  assign tgtSec = (cpuAddr >= FLASH_BASE) || ((cpuAddr >= RAM_BASE) && (cpuAddr <= RAM_LAST));
  assign orgSec = (cpuFetchAddr >= FLASH_BASE) || ((cpuFetchAddr >= RAM_BASE) && (cpuFetchAddr <= RAM_LAST));
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  AST_LOAD_CODE: assert property ($fell(srst) |-> secure == (optQ[1:0] != 2'h2))
    else $error("code load");
  AST_HOLD_CODE: assert property (!$past(srst) |-> !$rose(secure))
    else $error("security rose");
  AST_BLOCK_RD: assert property (secure && cpuRead && tgtSec && (bdcAccess || !orgSec) |->
    accessBlocked && cpuRdata == 8'h00) else $error("read not blocked");
  AST_BLOCK_WR: assert property (secure && cpuWrite && tgtSec && (bdcAccess || !orgSec) |-> !memWrite)
    else $error("write not blocked");
  AST_SEC_ORIGIN: assert property (cpuRead && !bdcAccess && orgSec |-> !accessBlocked && cpuRdata == memRdata)
    else $error("secure code limited");
  AST_OPEN_REGS: assert property (cpuRead && !tgtSec |-> !accessBlocked && cpuRdata == memRdata)
    else $error("register blocked");
  AST_DEBUG_GATE: assert property (secure |-> !debugEnable)
    else $error("debug while secure");
  AST_BGND_PIN: assert property ($fell(srst) |-> activeBackground == !pinQ)
    else $error("background mode");
  AST_VEC_MAP: assert property (cpuRead && cpuVectorFetch |-> memAddr == ((redirOn &&
    cpuAddr >= 16'hFFC0 && cpuAddr <= 16'hFFFD) ? cpuAddr + protStart : cpuAddr)) else $error("vector address");
  AST_VEC_GUARD: assert property (flashPgmReq && !protQ[0] && flashPgmAddr >= protStart |-> !flashPgmGrant)
    else $error("protected program");
endmodule
bind msv_memory_security msv_memory_security_props #(.FLASH_BASE(FLASH_BASE), .RAM_BASE(RAM_BASE),
  .RAM_LAST(RAM_LAST)) u_msv_memory_security_props (.ref_clk, .srst, .nvOptByte, .nvProtByte,
  .backgroundModePin, .cpuFetchAddr, .cpuAddr, .cpuRead, .cpuWrite, .cpuVectorFetch, .bdcAccess, .memRdata,
  .memAddr, .memWrite, .cpuRdata, .accessBlocked, .flashPgmAddr, .flashPgmReq, .flashPgmGrant, .debugEnable,
  .activeBackground, .secure);
`default_nettype wire

// *** sim/msv_mem_model.sv ***
// Behavioural flash and RAM array behind the gate
`timescale 1ns/1ps
`default_nettype none
module msv_mem_model (
  input wire logic ref_clk,
  input wire logic [15:0] memAddr,
  input wire logic memRead,
  output logic [7:0] memRdata
);
  // ----------------------------------------
  // Contents are a fold of the address
  // ----------------------------------------
  // Off read the bus shows the inverted last byte, never a stale copy
  logic [7:0] lastQ = 8'hA5;
  always_ff @(posedge ref_clk) begin
    if (memRead) begin
      lastQ <= memAddr[15:8] ^ memAddr[7:0];
    end
  end
  assign memRdata = memRead ? (memAddr[15:8] ^ memAddr[7:0]) : ~lastQ;
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
// Self-checking bench for the memory security block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import msv_pkg::*;
  localparam logic [63:0] KEY = 64'h0123_4567_89AB_CDEF;
  logic ref_clk = 1'b0, srst = 1'b1, backgroundModePin = 1'b1, powerOnEvent = 1'b0, stop1Wakeup = 1'b0;
  logic massEraseBlankOk = 1'b0, cpuRead = 1'b0, cpuWrite = 1'b0, cpuVectorFetch = 1'b0, bdcAccess = 1'b0;
  logic keyByteValid = 1'b0, flashPgmReq = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [7:0] nvOptByte = 8'hFF, nvProtByte = 8'hFF, keyByte = 8'h00, memRdata, cpuRdata;
  logic [63:0] nvBackKey = KEY;
  logic [15:0] cpuFetchAddr = 16'h0000, cpuAddr = 16'h0000, flashPgmAddr = 16'h0000, memAddr;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, rd;
  logic memRead, memWrite, accessBlocked, flashPgmGrant, debugEnable, activeBackground, secure, avs_waitrequest;
  logic [7:0] optT [3] = '{8'h03, 8'h03, 8'h43};
  logic [7:0] protT [3] = '{8'hFE, 8'hF8, 8'hFE};
  logic [15:0] vecT [5] = '{16'hFFC0, 16'hFFE0, 16'hFFFD, 16'hFFFE, 16'hFFFF};
  int err_count = 0, n_compared = 0;
  msv_memory_security u_msv_memory_security (.ref_clk, .srst, .nvOptByte, .nvProtByte, .nvBackKey,
    .backgroundModePin, .powerOnEvent, .stop1Wakeup, .massEraseBlankOk, .cpuFetchAddr, .cpuAddr, .cpuRead,
    .cpuWrite, .cpuVectorFetch, .bdcAccess, .memRdata, .memAddr, .memRead, .memWrite, .cpuRdata, .accessBlocked,
    .keyByteValid, .keyByte, .flashPgmAddr, .flashPgmReq, .flashPgmGrant, .debugEnable, .activeBackground,
    .secure, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest);
  msv_mem_model u_msv_mem_model (.ref_clk, .memAddr, .memRead, .memRdata);
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  // ----------------------------------------
  // Bus and access tasks
  // ----------------------------------------
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
      err_count++;
    end
  endtask
  task automatic rst(input logic [7:0] o, input logic [7:0] p, input logic pin);
    @(posedge ref_clk);
    {srst, nvOptByte, nvProtByte, backgroundModePin} <= {1'b1, o, p, pin};
    repeat (16) @(posedge ref_clk);
    srst <= 1'b0;
  endtask
  // Waitrequest is sampled at the edge, before that edge's updates land
  task automatic avs(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge ref_clk);
    {avs_address, avs_writedata, avs_write, avs_read} <= {a, d, wr, !wr};
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) begin
      $display("MISMATCH %0t bus wait timed out", $time);
      err_count++;
      give_verdict();
    end else begin
      rd = avs_readdata;
      {avs_write, avs_read} <= 2'b00;
    end
  endtask
  // Mode bits: read, write, background, vector fetch
  task automatic acc(input logic [15:0] f, input logic [15:0] a, input logic [3:0] m);
    @(posedge ref_clk);
    {cpuFetchAddr, cpuAddr, cpuRead, cpuWrite, bdcAccess, cpuVectorFetch} <= {f, a, m};
    @(negedge ref_clk);
  endtask
  task automatic keys(input logic [15:0] f, input logic b);
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk);
      {keyByteValid, keyByte, cpuFetchAddr, bdcAccess} <= {1'b1, KEY[8*i +: 8], f, b};
    end
    @(posedge ref_clk);
    keyByteValid <= 1'b0;
    repeat (2) @(negedge ref_clk);
  endtask
  task automatic pulse(input logic [2:0] m);
    @(posedge ref_clk);
    {massEraseBlankOk, stop1Wakeup, powerOnEvent} <= m;
    @(posedge ref_clk);
    {massEraseBlankOk, stop1Wakeup, powerOnEvent} <= 3'b000;
    @(negedge ref_clk);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    rst(MSV_OPT_ERASED, 8'hFF, 1'b1);
    avs(1'b0, MSV_REG_OPTION, 0);
    chk(rd, 32'h0000_00FF, "opt");
    acc(16'h0010, 16'hF900, 4'b1000);
    chk(32'(cpuRdata), 0, "unsec rd");
    acc(16'hF900, 16'h0080, 4'b1010);
    chk(32'(accessBlocked), 1, "bdc rd");
    acc(16'h0010, 16'hF900, 4'b0110);
    chk(32'(memWrite), 0, "bdc wr");
    acc(16'hF900, 16'hF900, 4'b1000);
    chk(32'(cpuRdata), 32'h0000_00F9, "sec rd");
    acc(16'h0010, 16'h0020, 4'b1010);
    chk(32'(cpuRdata), 32'h0000_0020, "reg rd");
    avs(1'b0, 4'h2, 0);
    chk(rd, 0, "unmapped");
    nvOptByte <= 8'h02;
    avs(1'b1, MSV_REG_CTRL, 32'h0000_0001);
    avs(1'b0, MSV_REG_STATUS, 0);
    chk(32'(rd[7:0] & 8'h41), 1, "status");
    avs(1'b0, MSV_REG_CTRL, 0);
    chk(rd, 32'h0000_0001, "ctrl rd");
    $display("test erased done");
    for (int c = 0; c < 4; c++) begin
      rst({6'h00, 2'(c)}, 8'hFF, 1'b1);
      acc(16'h0010, 16'h0080, 4'b1000);
      chk(32'(accessBlocked), 32'(c != 2), "code");
      avs(1'b1, MSV_REG_CTRL, 32'h0000_0001);
      @(negedge ref_clk);
      chk(32'(debugEnable), 32'(c == 2), "dbg");
    end
    $display("test codes done");
    rst(8'hC3, 8'hFF, 1'b1);
    keys(16'hF900, 1'b1);
    chk(32'(secure), 1, "bdc key");
    keys(16'hF900, 1'b0);
    chk(32'(secure), 0, "key");
    avs(1'b0, MSV_REG_STATUS, 0);
    chk(32'(rd[7:0] & 8'h03), 32'h0000_0002, "key flag");
    rst(8'hC3, 8'hFF, 1'b1);
    nvBackKey <= ~KEY;
    keys(16'hF900, 1'b0);
    avs(1'b0, MSV_REG_STATUS, 0);
    chk(32'(rd[7:0] & 8'h81), 32'h0000_0081, "bad key");
    nvBackKey <= KEY;
    rst(8'h43, 8'hFF, 1'b1);
    keys(16'hF900, 1'b0);
    chk(32'(secure), 1, "key off");
    pulse(3'b100);
    chk(32'(secure), 0, "blank");
    avs(1'b0, MSV_REG_STATUS, 0);
    chk(32'(rd[7:0] & 8'h05), 32'h0000_0004, "blank flag");
    $display("test key done");
    for (int k = 0; k < 3; k++) begin
      rst(optT[k], protT[k], 1'b1);
      foreach (vecT[j]) begin
        acc(16'hF900, vecT[j], 4'b1001);
        chk(32'(memAddr), 32'((k == 0 && vecT[j] < 16'hFFFE) ? vecT[j] - 16'h0200 : vecT[j]), "vec");
      end
      avs(1'b0, MSV_REG_PROTECT, 0);
      chk(rd, 32'(protT[k]), "prot");
      avs(1'b0, MSV_REG_STATUS, 0);
      chk(32'(rd[MSV_ST_REDIR_ACTIVE]), 32'(k == 0), "redir");
    end
    @(posedge ref_clk);
    {flashPgmAddr, flashPgmReq} <= {16'hFFC0, 1'b1};
    @(negedge ref_clk);
    chk(32'(flashPgmGrant), 0, "vec pgm");
    @(posedge ref_clk);
    flashPgmAddr <= 16'hF900;
    @(negedge ref_clk);
    chk(32'(flashPgmGrant), 1, "pgm");
    $display("test redirect done");
    rst(8'h02, 8'hFF, 1'b0);
    @(negedge ref_clk);
    chk(32'(activeBackground), 1, "pin low");
    pulse(3'b001);
    rst(8'h02, 8'hFF, 1'b1);
    @(negedge ref_clk);
    chk(32'(activeBackground), 0, "pin high");
    avs(1'b0, MSV_REG_STATUS, 0);
    chk(32'(rd[MSV_ST_RAM_UNDEF]), 1, "ram kept flag");
    avs(1'b1, MSV_REG_CTRL, 32'h0000_0002);
    avs(1'b0, MSV_REG_STATUS, 0);
    chk(32'(rd[MSV_ST_RAM_UNDEF]), 0, "ram clr");
    pulse(3'b010);
    avs(1'b0, MSV_REG_STATUS, 0);
    chk(32'(rd[MSV_ST_RAM_UNDEF]), 1, "stop1");
    $display("test mode and ram done");
    give_verdict();
  end
endmodule
`default_nettype wire
